// ### hdl/charger_pkg.sv
// Shared constants and carrier types for the charger status pin logic
package charger_pkg;

  // Clock rate and fault pulse timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned FAULT_PULSE_NS = 256_000;
  localparam int unsigned FAULT_PULSE_CYC = FAULT_PULSE_NS / (1_000_000_000 / CLK_HZ);

  // Thermistor classification
  localparam int unsigned TS_WIDTH = 10;
  localparam int unsigned TS_THRESH_N = 4;

  // Limit select codes {hi, lo}
  localparam logic [1:0] SEL_500MA = 2'h0;
  localparam logic [1:0] SEL_PROGRAMMED = 2'h1;
  localparam logic [1:0] SEL_100MA = 2'h2;
  localparam logic [1:0] SEL_HIZ = 2'h3;

  // Input limit modes
  typedef enum logic [1:0] {
    LIM_500MA = 2'h0,
    LIM_PROGRAMMED = 2'h1,
    LIM_100MA = 2'h2,
    LIM_HIZ = 2'h3
  } limit_mode_t;

  // Regulation threshold source
  typedef enum logic [1:0] {
    REG_FIXED_4V36 = 2'h0,
    REG_PROGRAMMED = 2'h1,
    REG_NONE = 2'h2
  } reg_mode_t;

  // Decoded input configuration
  typedef struct packed {
    limit_mode_t limit;
    reg_mode_t regulation;
  } input_cfg_t;

  // Reset value of the applied configuration
  localparam input_cfg_t INPUT_CFG_RESET = '{limit: LIM_500MA, regulation: REG_FIXED_4V36};

  // Charge progress from the charge controller
  typedef struct packed {
    logic supply_present;
    logic supply_valid;
    logic charging;
    logic recharge;
    logic done;
  } charge_state_t;

endpackage

// ### hdl/charger_status_pins.sv
// Charge enable, limit select and open-drain status pin logic of the charger
`timescale 1ns/1ps
`default_nettype none
module charger_status_pins
  import charger_pkg::*;
#(
  parameter bit HAS_DETECT = 1'b1,
  parameter int unsigned PULSE_CYC = FAULT_PULSE_CYC,
  parameter int unsigned TW = TS_WIDTH,
  parameter int unsigned TN = TS_THRESH_N
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic charge_enable_n,
  input wire logic limit_select_lo,
  input wire logic limit_select_hi,
  input wire logic detect_done,
  input wire charge_state_t charge_in,
  input wire logic fault,
  input wire logic status_enable,
  input wire logic [TW-1:0] thermistor_sense,
  input wire logic [TN*TW-1:0] thermistor_thresholds,
  output logic charger_run_q,
  output input_cfg_t input_cfg_q,
  output logic [TN-1:0] temp_zone_q,
  output logic charging_indicator_n_out_q,
  output logic charging_indicator_n_oe_q,
  output logic supply_good_n_out_q,
  output logic supply_good_n_oe_q,
  output logic status_n_out_q,
  output logic status_n_oe_q,
  output logic alert_n_out_q,
  output logic alert_n_oe_q
);
  initial begin
    if (PULSE_CYC < 1) $error("fault pulse must last at least one cycle");
  end

  logic enabled;
  logic [1:0] sel_now;
  logic [1:0] sel_seen_q;
  logic sel_armed_q;
  logic sel_primed_q;
  logic sel_change;
  logic fault_q;
  logic fault_rise;
  logic pulse_active;
  logic initial_cycle_q;
  logic ind_pull;
  logic good_pull;
  logic stat_pull;
  input_cfg_t cfg_d;

  assign enabled = !charge_enable_n;
  assign sel_now = {limit_select_hi, limit_select_lo};

  // Charger run command; high enable input forces standby
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      charger_run_q <= 1'b0;
    end else begin
      charger_run_q <= enabled && charge_in.supply_valid;
    end
  end

  always_comb begin
    unique case (sel_now)
      SEL_500MA: cfg_d = '{limit: LIM_500MA, regulation: REG_FIXED_4V36};
      SEL_PROGRAMMED: cfg_d = '{limit: LIM_PROGRAMMED, regulation: REG_PROGRAMMED};
      SEL_100MA: cfg_d = '{limit: LIM_100MA, regulation: REG_FIXED_4V36};
      SEL_HIZ: cfg_d = '{limit: LIM_HIZ, regulation: REG_NONE};
    endcase
  end

  // change seen only after one post-reset sample; the strap is not a change
  assign sel_change = sel_primed_q && (sel_now != sel_seen_q);

  // arm after detection, on first later select change
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_seen_q <= SEL_500MA;
      sel_armed_q <= 1'b0;
      sel_primed_q <= 1'b0;
    end else begin
      sel_seen_q <= sel_now;
      sel_primed_q <= 1'b1;
      if (!HAS_DETECT) begin
        sel_armed_q <= 1'b1;
      end else if (detect_done && sel_change) begin
        sel_armed_q <= 1'b1;
      end
    end
  end

  // Applied input configuration; held at reset value until armed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      input_cfg_q <= INPUT_CFG_RESET;
    end else if (sel_armed_q || !HAS_DETECT ||
                 (detect_done && sel_change)) begin
      input_cfg_q <= cfg_d;
    end
  end

  // tracks whether current charging is an initial cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      initial_cycle_q <= 1'b0;
    end else if (!charge_in.charging || !enabled || !charge_in.supply_present) begin
      initial_cycle_q <= 1'b0;
    end else if (!charge_in.recharge) begin
      initial_cycle_q <= 1'b1;
    end
  end

  assign ind_pull = enabled && charge_in.supply_present && charge_in.charging &&
                    !charge_in.done && !charge_in.recharge;

  assign good_pull = charge_in.supply_present && charge_in.supply_valid &&
                     (!HAS_DETECT || detect_done);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault;
    end
  end
  assign fault_rise = fault && !fault_q;

  pulse_stretch #(
    .WIDTH_CYC(PULSE_CYC)
  ) u_pulse (
    .clk(clk),
    .resetn(resetn),
    .trigger(fault_rise),
    .active(pulse_active)
  );

  assign stat_pull = status_enable && (pulse_active ||
                     (enabled && charge_in.charging && !charge_in.done));

  thermistor_zone #(
    .W(TW),
    .N(TN)
  ) u_zone (
    .clk(clk),
    .resetn(resetn),
    .sense(thermistor_sense),
    .thresholds(thermistor_thresholds),
    .above_q(temp_zone_q)
  );

  // open-drain drivers; out fixed low, enable low means pulling
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      charging_indicator_n_out_q <= 1'b0;
      charging_indicator_n_oe_q <= 1'b1;
      supply_good_n_out_q <= 1'b0;
      supply_good_n_oe_q <= 1'b1;
      status_n_out_q <= 1'b0;
      status_n_oe_q <= 1'b1;
      alert_n_out_q <= 1'b0;
      alert_n_oe_q <= 1'b1;
    end else begin
      charging_indicator_n_out_q <= 1'b0;
      charging_indicator_n_oe_q <= !(ind_pull && (initial_cycle_q || !charge_in.recharge));
      supply_good_n_out_q <= 1'b0;
      supply_good_n_oe_q <= !good_pull;
      status_n_out_q <= 1'b0;
      status_n_oe_q <= !stat_pull;
      alert_n_out_q <= 1'b0;
      alert_n_oe_q <= !stat_pull;
    end
  end
endmodule
`default_nettype wire

// ### hdl/pulse_stretch.sv
// Fixed-width pulse generator fired by a one-cycle trigger
`timescale 1ns/1ps
`default_nettype none
module pulse_stretch
  import charger_pkg::*;
#(
  parameter int unsigned WIDTH_CYC = FAULT_PULSE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic trigger,
  output logic active
);
  localparam int unsigned CW = $clog2(WIDTH_CYC + 1);

  initial begin
    if (WIDTH_CYC < 1) $error("pulse width must be at least one cycle");
  end

  logic [CW-1:0] count_q;

  // Reload on trigger, count down to zero; a new fault restarts the pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
    end else if (trigger) begin
      count_q <= CW'(WIDTH_CYC);
    end else if (count_q != '0) begin
      count_q <= count_q - CW'(1);
    end
  end

  assign active = (count_q != '0);
endmodule
`default_nettype wire

// ### hdl/thermistor_zone.sv
// Classifies the thermistor sense code against a set of thresholds
`timescale 1ns/1ps
`default_nettype none
module thermistor_zone
  import charger_pkg::*;
#(
  parameter int unsigned W = TS_WIDTH,
  parameter int unsigned N = TS_THRESH_N
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] sense,
  input wire logic [N*W-1:0] thresholds,
  output logic [N-1:0] above_q
);
  initial begin
    if (N < 1 || W < 1) $error("thermistor classifier needs thresholds and width");
  end

  // One registered comparator per threshold
  genvar i;
  for (i = 0; i < N; i++) begin : g_cmp
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        above_q[i] <= 1'b0;
      end else begin
        above_q[i] <= sense > thresholds[i*W +: W];
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/charger_status_monitor.sv
// Port assertions for the charger status pin logic
`timescale 1ns/1ps
`default_nettype none
module charger_status_monitor
  import charger_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic charge_enable_n,
  input wire logic limit_select_lo,
  input wire logic limit_select_hi,
  input wire logic detect_done,
  input wire charge_state_t charge_in,
  input wire logic fault,
  input wire logic status_enable,
  input wire logic charger_run_q,
  input wire input_cfg_t input_cfg_q,
  input wire logic charging_indicator_n_out_q,
  input wire logic charging_indicator_n_oe_q,
  input wire logic supply_good_n_out_q,
  input wire logic supply_good_n_oe_q,
  input wire logic status_n_out_q,
  input wire logic status_n_oe_q,
  input wire logic alert_n_out_q,
  input wire logic alert_n_oe_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic chg_on;
  // Initial charge cycle in progress
  assign chg_on = charge_in.charging && !charge_in.done && !charge_in.recharge
    && !charge_enable_n && charge_in.supply_present;
  a_run_standby: assert property (charge_enable_n |=> !charger_run_q)
    else $error("charger runs while disabled");
  a_chg_pull: assert property (chg_on |=> !charging_indicator_n_oe_q)
    else $error("charging indicator not pulled");
  a_chg_recharge: assert property (charge_in.recharge |=> charging_indicator_n_oe_q)
    else $error("charging indicator pulled in recharge");
  a_pg_pull: assert property (charge_in.supply_present && charge_in.supply_valid && detect_done
    |=> !supply_good_n_oe_q)
    else $error("supply good not pulled");
  a_stat_gate: assert property (!status_enable |=> status_n_oe_q)
    else $error("status pulled while disabled");
  a_od_low: assert property (!(status_n_out_q | alert_n_out_q | supply_good_n_out_q
    | charging_indicator_n_out_q))
    else $error("indication driven high");
  a_pulse_hold: assert property ($rose(fault) ##0 status_enable[*8] |=> !status_n_oe_q)
    else $error("fault pulse too short");
  a_pulse_end: assert property (($rose(fault) && !charge_in.charging)
    ##1 (!$rose(fault) && !charge_in.charging)[*8] ##1 !charge_in.charging
    |=> status_n_oe_q)
    else $error("fault pulse too long");
  a_alert_match: assert property (alert_n_oe_q == status_n_oe_q)
    else $error("alert differs from status");
  a_pg_release: assert property (!(charge_in.supply_present && charge_in.supply_valid)
    |=> supply_good_n_oe_q)
    else $error("supply good pulled without valid supply");
  a_pg_detect: assert property (!detect_done |=> supply_good_n_oe_q)
    else $error("supply good pulled before detection");
  a_chg_nosupply: assert property (!charge_in.supply_present |=> charging_indicator_n_oe_q)
    else $error("charging indicator pulled without supply");
  a_cfg_hold: assert property (!detect_done |=> $stable(input_cfg_q))
    else $error("select applied before detection");
  a_cfg_decode: assert property (detect_done && $past(detect_done)
    && $changed({limit_select_hi, limit_select_lo})
    |=> input_cfg_q.limit == limit_mode_t'($past({limit_select_hi, limit_select_lo})))
    else $error("limit select decode wrong");
endmodule
bind charger_status_pins charger_status_monitor i_charger_status_monitor (.*);
`default_nettype wire

// ### tb/host_pins.sv
// Host side model: pull-up resistors on the open-drain indication pins
`timescale 1ns/1ps
`default_nettype none
module host_pins (
  input wire logic [3:0] oe,
  input wire logic [3:0] out,
  output logic [3:0] level
);
  assign level = oe | out;
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the charger status pin logic
`timescale 1ns/1ps
`default_nettype none
module tb;
  import charger_pkg::*;
  localparam int unsigned PC = 8;
  logic clk, resetn, charge_enable_n, limit_select_lo, limit_select_hi, detect_done;
  logic fault, status_enable, run_q;
  charge_state_t charge_in;
  input_cfg_t cfg_q;
  logic [TS_WIDTH-1:0] sense;
  logic [TS_THRESH_N*TS_WIDTH-1:0] thr;
  logic [TS_THRESH_N-1:0] zone_q;
  logic [3:0] oe, out, pins;
  int seed = 10;
  int bad_count = 0;
  int tests_run = 0;
  int n;
  charger_status_pins #(.PULSE_CYC(PC)) i_charger_status_pins (.clk(clk), .resetn(resetn),
    .charge_enable_n(charge_enable_n), .limit_select_lo(limit_select_lo),
    .limit_select_hi(limit_select_hi), .detect_done(detect_done), .charge_in(charge_in),
    .fault(fault), .status_enable(status_enable), .thermistor_sense(sense),
    .thermistor_thresholds(thr), .charger_run_q(run_q), .input_cfg_q(cfg_q),
    .temp_zone_q(zone_q), .charging_indicator_n_out_q(out[3]),
    .charging_indicator_n_oe_q(oe[3]), .supply_good_n_out_q(out[2]),
    .supply_good_n_oe_q(oe[2]), .status_n_out_q(out[1]), .status_n_oe_q(oe[1]),
    .alert_n_out_q(out[0]), .alert_n_oe_q(oe[0]));
  host_pins i_host_pins (.oe(oe), .out(out), .level(pins));
  // Expected pin levels {charging, supply good, status, alert}
  function automatic logic [3:0] exp_pins(charge_state_t c, logic en_n, logic se, logic dd);
    logic charging_indicator_n, st;
    charging_indicator_n = c.charging && !c.done && !c.recharge && !en_n && c.supply_present;
    st = se && c.charging && !c.done && !en_n;
    return {!charging_indicator_n, !(c.supply_present && c.supply_valid && dd), !st, !st};
  endfunction
  // Expected zone bits, one per threshold
  function automatic logic [3:0] exp_zone(logic [TS_WIDTH-1:0] s);
    for (int i = 0; i < TS_THRESH_N; i++) exp_zone[i] = s > thr[i*TS_WIDTH +: TS_WIDTH];
  endfunction
  // Compare and count
  task automatic check(logic [31:0] got, logic [31:0] exp, string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Watchdog
  initial begin
    #20000;
    bad_count++;
    conclude();
  end
  // Main sequence
  initial begin
    {resetn, limit_select_lo, limit_select_hi, detect_done, fault, status_enable} = '0;
    charge_enable_n = 1'b1;
    charge_in = '0;
    sense = '0;
    thr = '0;
    repeat (8) @(negedge clk);
    check(pins, 4'hf, "pins in reset");
    resetn = 1'b1;
    {limit_select_hi, limit_select_lo} = SEL_100MA;
    @(negedge clk);
    check(cfg_q, INPUT_CFG_RESET, "cfg before detect");
    detect_done = 1'b1;
    repeat (2) @(negedge clk);
    check(cfg_q, INPUT_CFG_RESET, "cfg without change");
    for (int k = 0; k < 4; k++) begin
      {limit_select_hi, limit_select_lo} = 2'(k);
      @(negedge clk);
      check(cfg_q, {limit_mode_t'(k), k == SEL_PROGRAMMED ? REG_PROGRAMMED
        : k == SEL_HIZ ? REG_NONE : REG_FIXED_4V36}, "cfg decode");
    end
    $display("test select done");
    for (int e = 1; e >= 0; e--) begin
      status_enable = 1'(e);
      fault = 1'b1;
      n = 0;
      repeat (PC + 4) begin
        @(negedge clk);
        n += int'(pins[1:0] == 2'b00);
      end
      check(n, e * PC, "fault pulse width");
      fault = 1'b0;
      @(negedge clk);
    end
    $display("test fault done");
    repeat (300) begin
      charge_in = 5'($random(seed));
      charge_in.supply_valid &= charge_in.supply_present;
      {charge_enable_n, status_enable, detect_done} = 3'($random(seed));
      thr = (TS_THRESH_N * TS_WIDTH)'({$random(seed), $random(seed)});
      sense = ($random(seed) % 4 == 0) ? thr[TS_WIDTH-1:0] : TS_WIDTH'($random(seed));
      @(negedge clk);
      check(pins, exp_pins(charge_in, charge_enable_n, status_enable, detect_done), "pins");
      check(run_q, !charge_enable_n && charge_in.supply_valid, "run");
      check(zone_q, exp_zone(sense), "zone");
    end
    $display("test random done");
    conclude();
  end
endmodule
`default_nettype wire
